// File: hdl/express_cfg_pkg.sv
// shared constants and carrier types for the configuration register block
package express_cfg_pkg;

    // ==========================================================
    // configuration offsets (byte addresses, 12-bit config space)
    localparam logic [11:0] DEV_STATUS_OFF = 12'h09A;
    localparam logic [11:0] LINK_CAP_OFF = 12'h09C;
    localparam logic [11:0] LINK_CTL_OFF = 12'h0A0;

    // ==========================================================
    // device status field positions and reset value
    localparam int ST_PENDING_BIT = 5;
    localparam int ST_AUX_BIT = 4;
    localparam int ST_ERR_LSB = 0;
    localparam int ST_ERR_W = 4;
    localparam logic [15:0] DEV_STATUS_RESET = 16'h0000;

    // ==========================================================
    // link capabilities field values
    localparam logic [7:0] LCAP_PORT_NUM = 8'h00;
    localparam logic [5:0] LCAP_RSVD = 6'h00;
    localparam logic [2:0] LCAP_L0S_COMMON = 3'h3;
    localparam logic [2:0] LCAP_L0S_ASYNC = 3'h4;
    localparam logic [1:0] LCAP_ASPM_SUPPORT = 2'h3;
    localparam logic [5:0] LCAP_MAX_WIDTH = 6'h01;
    localparam logic [3:0] LCAP_MAX_SPEED = 4'h1;

    // ==========================================================
    // link control field positions, writable mask and reset value
    localparam int LCTL_EXT_SYNC_BIT = 7;
    localparam int LCTL_CCC_BIT = 6;
    localparam int LCTL_RCB_BIT = 3;
    localparam int LCTL_ASPM_LSB = 0;
    localparam logic [15:0] LCTL_RW_MASK = 16'h00CB;
    localparam logic [15:0] LCTL_RESET = 16'h0000;

    // ==========================================================
    // outstanding nonposted tracker
    localparam int NP_CNT_W = 5;
    localparam logic [4:0] NP_CNT_MAX = 5'h1F;
    localparam logic [4:0] NP_CNT_RESET = 5'h00;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    // order matches status bits 3..0
    typedef struct packed {
        logic unsupported_request;
        logic fatal_error;
        logic nonfatal_error;
        logic correctable_error;
    } err_evt_t;

endpackage

// File: hdl/sticky_flag_bank.sv
// four sticky error-seen flags, set by events, cleared by write-one
`timescale 1ns/1ps
module sticky_flag_bank (
    input wire logic ref_clk,
    input wire logic rst,
    input wire express_cfg_pkg::err_evt_t set_evt,
    input wire logic [3:0] clear_mask,
    output logic [3:0] flags
);

    typedef struct packed {
        logic [3:0] flags;
    } bank_state_t;

    bank_state_t s_q;
    bank_state_t s_d;

    // ==========================================================
    // flag update
    always_comb begin
        s_d = s_q;
        for (int i = 0; i < 4; i++) begin
            // set beats a same-cycle clear so no event is lost
            s_d.flags[i] = (s_q.flags[i] & ~clear_mask[i]) | set_evt[i]; // (R8)
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flags = s_q.flags;

endmodule // sticky_flag_bank

// File: hdl/np_tracker.sv
// counts nonposted requests still waiting for their completion
`timescale 1ns/1ps
module np_tracker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic np_issue,
    input wire logic np_complete,
    output logic outstanding_nonposted
);

    typedef struct packed {
        logic [express_cfg_pkg::NP_CNT_W-1:0] count;
    } np_state_t;

    np_state_t s_q;
    np_state_t s_d;

    // ==========================================================
    // counter
    always_comb begin
        s_d = s_q;
        // saturate rather than wrap; a wrap would falsely show idle
        if (np_issue && !np_complete && s_q.count != express_cfg_pkg::NP_CNT_MAX) begin
            s_d.count = s_q.count + 5'h01;
        end else if (!np_issue && np_complete && s_q.count != 5'h00) begin
            s_d.count = s_q.count - 5'h01;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q.count <= express_cfg_pkg::NP_CNT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign outstanding_nonposted = (s_q.count != 5'h00); // (R2)

endmodule // np_tracker

// File: hdl/express_dev_status_link_caps.sv
// device status, link capabilities and link control configuration registers
//
// Functional notes
// (R1) device status bits 15:6 read zero
// (R2) bit 5 high while nonposted requests outstanding
// (R3) bit 4 shows auxiliary power present
// (R4) bit 3 set on unsupported request
// (R5) bit 2 set on fatal error
// (R6) bit 1 set on nonfatal error
// (R7) bit 0 set on correctable error
// (R8) error flags sticky, cleared by writing one
// (R9) link capabilities at 9Ch, read-only
// (R10) port number field reads 00h
// (R11) link capabilities bits 23:18 read zero
// (R12) exit times selected by common clock bit
// (R13) common clock: l1 from diag bits 20:18
// (R14) async clock: l1 from diag bits 17:15
// (R15) common clock: l0s exit reads 011b
// (R16) async clock: l0s exit reads 100b
// (R17) aspm support field reads 11b
// (R18) max link width reads 000001b
// (R19) max link speed reads 1h
// (R20) link control at A0h, resets zero
`timescale 1ns/1ps
module express_dev_status_link_caps (
    input wire logic ref_clk,
    input wire logic rst,
    input wire express_cfg_pkg::cfg_req_t cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_rd_valid,
    input wire logic np_issue,
    input wire logic np_complete,
    input wire logic aux_power_pin,
    input wire express_cfg_pkg::err_evt_t err_evt,
    input wire logic [2:0] diag_l1_exit_value_a,
    input wire logic [2:0] diag_l1_exit_value_b,
    output logic [15:0] link_control,
    output logic common_clock_cfg,
    output logic extended_sync,
    output logic read_completion_boundary,
    output logic [1:0] aspm_control,
    output logic [15:0] device_status
);

    // ==========================================================
    // state
    typedef struct packed {
        logic aux_meta;
        logic aux_power_present;
        logic [15:0] link_ctl;
        logic [31:0] rdata;
        logic rd_valid;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    logic outstanding_nonposted;
    logic [3:0] err_flags;
    logic [3:0] err_clear;
    logic status_wr_hit;
    logic ctl_wr_hit;
    logic [15:0] status_word;
    logic [31:0] link_cap_word;

    // ==========================================================
    // decode helpers
    // a register hits when the access falls in its aligned dword
    function automatic logic dw_hit(
        input logic [11:0] addr,
        input logic [11:0] off
    );
        dw_hit = (addr[11:2] == off[11:2]);
    endfunction

    // position of a 16-bit register inside its dword
    function automatic logic upper_half(
        input logic [11:0] off
    );
        upper_half = off[1];
    endfunction

    // merge writable bits of a half-word under two byte enables
    function automatic logic [15:0] half_merge(
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [1:0] be,
        input logic [15:0] rw_mask
    );
        logic [15:0] lane_mask;
        lane_mask = {{8{be[1]}}, {8{be[0]}}} & rw_mask;
        half_merge = (old_val & ~lane_mask) | (new_val & lane_mask);
    endfunction

    // select the half-word of write data or byte enables for a register
    function automatic logic [15:0] half_data(
        input logic [31:0] data,
        input logic [11:0] off
    );
        half_data = upper_half(off) ? data[31:16] : data[15:0];
    endfunction

    function automatic logic [1:0] half_be(
        input logic [3:0] be,
        input logic [11:0] off
    );
        half_be = upper_half(off) ? be[3:2] : be[1:0];
    endfunction

    // place a half-word at its lane within the dword
    function automatic logic [31:0] half_place(
        input logic [15:0] val,
        input logic [11:0] off
    );
        half_place = upper_half(off) ? {val, 16'h0000} : {16'h0000, val};
    endfunction

    // ==========================================================
    // link capabilities assembly
    function automatic logic [31:0] build_link_cap(
        input logic ccc,
        input logic [2:0] l1_common,
        input logic [2:0] l1_async
    );
        logic [2:0] l1_exit_time;
        logic [2:0] l0s_exit_time;
        l1_exit_time = ccc ? l1_common : l1_async; // (R12) (R13) (R14)
        l0s_exit_time = ccc ? express_cfg_pkg::LCAP_L0S_COMMON // (R15)
                            : express_cfg_pkg::LCAP_L0S_ASYNC; // (R16)
        build_link_cap = {
            express_cfg_pkg::LCAP_PORT_NUM, // (R10)
            express_cfg_pkg::LCAP_RSVD, // (R11)
            l1_exit_time,
            l0s_exit_time,
            express_cfg_pkg::LCAP_ASPM_SUPPORT, // (R17)
            express_cfg_pkg::LCAP_MAX_WIDTH, // (R18)
            express_cfg_pkg::LCAP_MAX_SPEED // (R19)
        };
    endfunction

    // ==========================================================
    // device status assembly
    function automatic logic [15:0] build_status(
        input logic pending,
        input logic aux,
        input logic [3:0] errs
    );
        logic [15:0] w;
        w = express_cfg_pkg::DEV_STATUS_RESET; // (R1)
        w[express_cfg_pkg::ST_PENDING_BIT] = pending; // (R2)
        w[express_cfg_pkg::ST_AUX_BIT] = aux; // (R3)
        w[express_cfg_pkg::ST_ERR_LSB +: express_cfg_pkg::ST_ERR_W] = errs;
        build_status = w;
    endfunction

    // ==========================================================
    // sub-blocks
    np_tracker u_np_tracker (
        .ref_clk(ref_clk),
        .rst(rst),
        .np_issue(np_issue),
        .np_complete(np_complete),
        .outstanding_nonposted(outstanding_nonposted)
    );

    // each event line maps onto its own status bit
    sticky_flag_bank u_sticky_flag_bank (
        .ref_clk(ref_clk),
        .rst(rst),
        .set_evt(err_evt), // (R4) (R5) (R6) (R7)
        .clear_mask(err_clear),
        .flags(err_flags)
    );

    // ==========================================================
    // write decode
    assign status_wr_hit = cfg_req.wr_en && dw_hit(cfg_req.addr, express_cfg_pkg::DEV_STATUS_OFF);
    assign ctl_wr_hit = cfg_req.wr_en && dw_hit(cfg_req.addr, express_cfg_pkg::LINK_CTL_OFF);

    // write one clears; a zero or a disabled lane leaves the flag alone
    always_comb begin
        logic [15:0] st_wdata;
        logic [1:0] st_be;
        st_wdata = half_data(cfg_req.wdata, express_cfg_pkg::DEV_STATUS_OFF);
        st_be = half_be(cfg_req.be, express_cfg_pkg::DEV_STATUS_OFF);
        err_clear = '0;
        if (status_wr_hit && st_be[0]) begin
            err_clear = st_wdata[express_cfg_pkg::ST_ERR_LSB +: express_cfg_pkg::ST_ERR_W]; // (R8)
        end
    end

    // ==========================================================
    // read-side words
    assign status_word = build_status(outstanding_nonposted, s_q.aux_power_present, err_flags);

    assign link_cap_word = build_link_cap(
        s_q.link_ctl[express_cfg_pkg::LCTL_CCC_BIT],
        diag_l1_exit_value_a,
        diag_l1_exit_value_b
    );

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;

        // aux power arrives from a pin; two stages before use
        s_d.aux_meta = aux_power_pin;
        s_d.aux_power_present = s_q.aux_meta; // (R3)

        // link control: only documented writable bits take the write
        if (ctl_wr_hit) begin
            s_d.link_ctl = half_merge(
                s_q.link_ctl,
                half_data(cfg_req.wdata, express_cfg_pkg::LINK_CTL_OFF),
                half_be(cfg_req.be, express_cfg_pkg::LINK_CTL_OFF),
                express_cfg_pkg::LCTL_RW_MASK
            ); // (R20)
        end

        // link capabilities takes no write at all
        // read data: registered, one cycle after the request
        s_d.rd_valid = cfg_req.rd_en;
        if (cfg_req.rd_en) begin
            if (dw_hit(cfg_req.addr, express_cfg_pkg::DEV_STATUS_OFF)) begin
                s_d.rdata = half_place(status_word, express_cfg_pkg::DEV_STATUS_OFF);
            end else if (dw_hit(cfg_req.addr, express_cfg_pkg::LINK_CAP_OFF)) begin
                s_d.rdata = link_cap_word; // (R9)
            end else if (dw_hit(cfg_req.addr, express_cfg_pkg::LINK_CTL_OFF)) begin
                s_d.rdata = half_place(s_q.link_ctl, express_cfg_pkg::LINK_CTL_OFF);
            end else begin
                // other space belongs elsewhere; answer zero
                s_d.rdata = 32'h00000000;
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q.aux_meta <= 1'b0;
            s_q.aux_power_present <= 1'b0;
            s_q.link_ctl <= express_cfg_pkg::LCTL_RESET; // (R20)
            s_q.rdata <= 32'h00000000;
            s_q.rd_valid <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign cfg_rdata = s_q.rdata;
    assign cfg_rd_valid = s_q.rd_valid;
    assign link_control = s_q.link_ctl;
    assign common_clock_cfg = s_q.link_ctl[express_cfg_pkg::LCTL_CCC_BIT];
    assign extended_sync = s_q.link_ctl[express_cfg_pkg::LCTL_EXT_SYNC_BIT];
    assign read_completion_boundary = s_q.link_ctl[express_cfg_pkg::LCTL_RCB_BIT];
    assign aspm_control = s_q.link_ctl[express_cfg_pkg::LCTL_ASPM_LSB +: 2];
    assign device_status = status_word;

endmodule // express_dev_status_link_caps

// File: bench/status_caps_monitor.sv
// assertion checker for the status and link capability register block
`timescale 1ns/1ps
module status_caps_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire express_cfg_pkg::cfg_req_t cfg_req,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rd_valid,
    input wire logic np_issue,
    input wire logic np_complete,
    input wire logic aux_power_pin,
    input wire express_cfg_pkg::err_evt_t err_evt,
    input wire logic [2:0] diag_l1_exit_value_a,
    input wire logic [2:0] diag_l1_exit_value_b,
    input wire logic [15:0] link_control,
    input wire logic common_clock_cfg,
    input wire logic [1:0] aspm_control,
    input wire logic [15:0] device_status
);
    // ==========================================
    // helpers
    logic [9:0] dw;
    logic [3:0] clr;
    logic [3:0] keep;
    logic [31:0] lcap;
    logic [2:0] l1;
    assign dw = cfg_req.addr[11:2];
    assign clr = (cfg_req.wr_en && dw == 10'h026 && cfg_req.be[2]) ? cfg_req.wdata[19:16] : 4'h0;
    assign keep = device_status[3:0] & ~clr;
    assign l1 = common_clock_cfg ? diag_l1_exit_value_a : diag_l1_exit_value_b;
    assign lcap = {14'h0000, l1, common_clock_cfg ? 3'h3 : 3'h4, 12'hC11};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ==========================================
    // assertions
    AST_RSVD: assert property (device_status[15:6] == 10'h000)
        else $error("status reserved bits not zero");
    AST_OUTSTANDING_NONPOSTED: assert property ((np_issue && !np_complete) |=> device_status[5])
        else $error("pending bit low after issue");
    AST_AUX: assert property ($stable(aux_power_pin)[*3] |-> device_status[4] == aux_power_pin)
        else $error("aux bit does not follow pin");
    AST_FLAGSET: assert property ((|err_evt) |=> ((device_status[3:0] & $past(err_evt)) == $past(err_evt)))
        else $error("error flag not set by event");
    AST_STICKY: assert property (1'b1 |=> ((device_status[3:0] & $past(keep)) == $past(keep)))
        else $error("error flag lost without clear");
    AST_CLEAR: assert property ((clr[2] && !err_evt.fatal_error) |=> !device_status[2])
        else $error("write one did not clear flag");
    AST_RDV: assert property (1'b1 |=> cfg_rd_valid == $past(cfg_req.rd_en))
        else $error("read valid timing wrong");
    AST_LCAP: assert property ((cfg_req.rd_en && dw == 10'h027) |=> cfg_rdata == $past(lcap))
        else $error("link capability read wrong");
    AST_LCTL: assert property ((cfg_req.wr_en && dw == 10'h028 && cfg_req.be[0]) |=>
        link_control == {8'h00, $past(cfg_req.wdata[7:0]) & 8'hCB})
        else $error("link control write wrong");
    AST_RO: assert property ((cfg_req.wr_en && dw != 10'h028) |=> $stable(link_control))
        else $error("link control changed by other write");
    AST_ALIAS: assert property (common_clock_cfg == link_control[6] && aspm_control == link_control[1:0])
        else $error("link control outputs disagree");

    C_FATAL: cover property (err_evt.fatal_error);
    C_CLEAR: cover property (clr[2] && device_status[2]);
    C_CAPCC: cover property (cfg_req.rd_en && dw == 10'h027 && common_clock_cfg);
endmodule // status_caps_monitor

bind express_dev_status_link_caps status_caps_monitor i_mon (
    .ref_clk(ref_clk),
    .rst(rst),
    .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata),
    .cfg_rd_valid(cfg_rd_valid),
    .np_issue(np_issue),
    .np_complete(np_complete),
    .aux_power_pin(aux_power_pin),
    .err_evt(err_evt),
    .diag_l1_exit_value_a(diag_l1_exit_value_a),
    .diag_l1_exit_value_b(diag_l1_exit_value_b),
    .link_control(link_control),
    .common_clock_cfg(common_clock_cfg),
    .aspm_control(aspm_control),
    .device_status(device_status)
);

// File: bench/express_dev_status_link_caps_tb.sv
// self-checking bench for the status and link capability register block
`timescale 1ns/1ps
module express_dev_status_link_caps_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    express_cfg_pkg::cfg_req_t req = '0;
    logic np_issue = 1'b0;
    logic np_complete = 1'b0;
    logic aux_pin = 1'b0;
    express_cfg_pkg::err_evt_t err = '0;
    logic [2:0] dva = 3'h0;
    logic [2:0] dvb = 3'h0;
    logic [31:0] rdata;
    logic rdv, ccc, es, rcb;
    logic [1:0] aspm;
    logic [15:0] lctl, stat;
    int errors = 0;
    int n_compared = 0;
    // lfsr seed 78214
    logic [31:0] r = 32'h0001_3186;
    logic [9:0] ad [4] = '{10'h026, 10'h027, 10'h028, 10'h03F};
    // ==========================================
    // reference model state
    logic [15:0] m_lc = 16'h0000;
    logic [3:0] m_fl = 4'h0;
    int m_np = 0;
    logic m_a1 = 1'b0;
    logic m_a2 = 1'b0;
    logic [31:0] m_rd = 32'h0;

    always #2.5 ref_clk = ~ref_clk;

    express_dev_status_link_caps i_dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .cfg_req(req),
        .cfg_rdata(rdata),
        .cfg_rd_valid(rdv),
        .np_issue(np_issue),
        .np_complete(np_complete),
        .aux_power_pin(aux_pin),
        .err_evt(err),
        .diag_l1_exit_value_a(dva),
        .diag_l1_exit_value_b(dvb),
        .link_control(lctl),
        .common_clock_cfg(ccc),
        .extended_sync(es),
        .read_completion_boundary(rcb),
        .aspm_control(aspm),
        .device_status(stat)
    );

    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one edge: model takes the inputs seen at the edge, then outputs are compared
    task automatic step();
        logic [15:0] st;
        logic [31:0] cap;
        logic [9:0] dw;
        logic v;
        @(posedge ref_clk);
        st = {10'h000, m_np > 0, m_a2, m_fl};
        cap = {14'h0000, m_lc[6] ? dva : dvb, m_lc[6] ? 3'h3 : 3'h4, 12'hC11};
        dw = req.addr[11:2];
        v = req.rd_en;
        if (v)
            m_rd = (dw == 10'h026) ? {st, 16'h0000} : (dw == 10'h027) ? cap :
                (dw == 10'h028) ? {16'h0000, m_lc} : 32'h0;
        if (req.wr_en && dw == 10'h026 && req.be[2])
            m_fl = m_fl & ~req.wdata[19:16];
        if (req.wr_en && dw == 10'h028 && req.be[0])
            m_lc = {8'h00, req.wdata[7:0] & 8'hCB};
        // set wins over a clear in the same cycle
        m_fl = m_fl | err;
        if (np_issue && !np_complete && m_np < 31)
            m_np++;
        if (np_complete && !np_issue && m_np > 0)
            m_np--;
        m_a2 = m_a1;
        m_a1 = aux_pin;
        #1;
        st = {10'h000, m_np > 0, m_a2, m_fl};
        chk("rd_valid", {31'h0, v}, {31'h0, rdv});
        // read data holds between reads, so it is compared every cycle
        chk("rd_data", m_rd, rdata);
        chk("status", {16'h0, st}, {16'h0, stat});
        chk("link_ctl", {11'h0, m_lc[6], m_lc[7], m_lc[3], m_lc[1:0], m_lc},
            {11'h0, ccc, es, rcb, aspm, lctl});
    endtask

    // outputs while reset is held
    task automatic rst_chk();
        chk("rst_ctl", 32'h0, {10'h0, rdv, ccc, es, rcb, aspm, lctl});
        chk("rst_stat", 32'h0, {16'h0, stat});
        chk("rst_rdata", 32'h0, rdata);
    endtask

    task automatic op(input logic rd, input logic wr, input logic [11:0] a, input logic [3:0] be,
        input logic [31:0] d);
        req <= {wr, rd, a, be, d};
        step();
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        rst_chk();
        rst = 1'b0;
        op(1'b1, 1'b0, 12'h0A0, 4'h0, 32'h0);
        op(1'b1, 1'b0, 12'h09C, 4'h0, 32'h0);
        op(1'b0, 1'b1, 12'h09C, 4'hF, 32'hFFFF_FFFF);
        op(1'b1, 1'b1, 12'h0A0, 4'h3, 32'hFFFF_FFFF);
        op(1'b1, 1'b0, 12'h09C, 4'h0, 32'h0);
        op(1'b1, 1'b0, 12'h0FC, 4'h0, 32'h0);
        // random traffic: rare events so sticky flags get cleared between them
        repeat (600) begin
            repeat (11) r = lfsr(r);
            err <= r[3:0] & r[7:4] & r[11:8];
            np_issue <= r[12] & r[13];
            np_complete <= r[14] & r[15];
            if (r[29:27] == 3'h0)
                aux_pin <= ~aux_pin;
            dva <= r[18:16];
            dvb <= r[21:19];
            op(r[22], r[23] & r[24], {ad[r[26:25]], r[31:30]},
                r[11:8] | r[7:4], {r[15:0], r[31:16] ^ {8'h00, r[7:0]}});
        end
        // mid-run reset with flags set; pin low so the sync restarts clean
        err <= '0;
        np_issue <= 1'b0;
        np_complete <= 1'b0;
        aux_pin <= 1'b0;
        rst = 1'b1;
        #1;
        rst_chk();
        repeat (2) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        m_lc = 16'h0000;
        m_fl = 4'h0;
        m_np = 0;
        m_a1 = 1'b0;
        m_a2 = 1'b0;
        m_rd = 32'h0;
        op(1'b1, 1'b0, 12'h098, 4'h0, 32'h0);
        op(1'b1, 1'b0, 12'h0A0, 4'h0, 32'h0);
        end_sim();
    end

    initial begin
        #20000;
        errors++;
        end_sim();
    end
endmodule // express_dev_status_link_caps_tb
